//--- dll_mode_switch_sequencer.sv
// controller-side sequencer switching a ddr3l dll on or off through self refresh
// Functional notes
// [RULE1] user starts only with device idle, rtt off
// [RULE2] enter self refresh, wait tCKSRE before clock change
// [RULE3] stable clock tCKSRX before self refresh exit
// [RULE4] cke high from exit until tDLLK
// [RULE5] odt low until tDLLK if termination used
// [RULE6] after tXS write mr1 a0 cleared
// [RULE7] after tMRD write mr0 a8 set
// [RULE8] after tMRD rewrite mode registers for new rate
// [RULE9] long zq calibration after tMOD
// [RULE10] ready after tMOD, locked after tDLLK
// [RULE11] add tZQoper when zq calibration issued
// [RULE12] dll off: mr1 a0 set, self refresh, reprogram
// [RULE13] mode register writes at least 4 clocks apart
// [RULE14] ns timings to cycles rounded up
// [RULE15] dll off needs cl 6 with cwl 6
// [RULE16] record termination use at self refresh entry
`default_nettype none
`include "dll_switch_consts.svh"
module dll_mode_switch_sequencer #(
    parameter int T_MRD = `T_MRD_CK, // mode register write spacing
    parameter int T_MOD = (`T_MOD_CK > `NS_TO_CYC(`T_MOD_NS)) ? `T_MOD_CK : `NS_TO_CYC(`T_MOD_NS),
    parameter int T_CKSRE = (`T_CKSRE_CK > `NS_TO_CYC(`T_CKSRE_NS)) ? `T_CKSRE_CK
        : `NS_TO_CYC(`T_CKSRE_NS),
    parameter int T_CKSRX = (`T_CKSRX_CK > `NS_TO_CYC(`T_CKSRX_NS)) ? `T_CKSRX_CK
        : `NS_TO_CYC(`T_CKSRX_NS),
    parameter int T_XS = `NS_TO_CYC(`T_XS_NS), // see [RULE14]
    parameter int T_DLLK = `T_DLLK_CK, // dll lock time
    parameter int T_ZQOPER = `T_ZQOPER_CK // long calibration time
) (
    input wire logic CLK, // 100 MHz controller clock
    input wire logic RST, // async reset, high
    input wire logic START, // one-cycle pulse, begin a switch
    input wire logic TO_DLL_ON, // 1: switch dll on, 0: switch off
    input wire logic ODT_FEATURES_ON, // termination enabled in mode registers
    input wire logic ZQ_LONG_EN, // issue long zq calibration
    input wire logic [15:0] MR0_VALUE, // new mr0 (cl, wr) without dll reset
    input wire logic [15:0] MR1_VALUE, // new mr1 settings
    input wire logic [15:0] MR2_VALUE, // new mr2 (cwl)
    input wire logic ODT_REQ, // user odt level outside the switch
    input wire logic CLK_STABLE, // async: new dram clock is stable
    output logic FREQ_CHANGE_OK, // clock may now change
    output logic BUSY, // sequence running
    output logic DONE, // one-cycle pulse, device ready
    output logic CKE, // dram clock enable
    output logic CS_N, // dram chip select
    output logic RAS_N, // dram row strobe
    output logic CAS_N, // dram column strobe
    output logic WE_N, // dram write enable
    output logic [2:0] BA, // dram bank address
    output logic [15:0] ADDR, // dram address
    output logic ODT // dram termination control
);
    dll_switch_pkg::pins_type pins;
    dll_switch_pkg::state_type state;
    dll_switch_pkg::state_type after;
    logic dll_on_dir;
    logic odt_used;
    logic [2:0] stable_sync;
    logic clk_ok;
    logic seq_load;
    logic [`TIMER_W-1:0] seq_count;
    logic seq_done;
    logic dllk_load;
    logic dllk_done;

    initial begin
        if (T_MRD < 4) $error("mode register spacing below 4 clocks"); // see [RULE13]
        if (T_MOD < T_MRD) $error("tMOD shorter than tMRD");
        if (T_DLLK >= (1 << `TIMER_W) || T_ZQOPER >= (1 << `TIMER_W)) $error("timer too narrow");
    end

    // ============================================================
    // timers: one for step gaps, one for the dll lock window
    wait_timer #(.WIDTH(`TIMER_W)) seq_timer (
        .clk(CLK),
        .rst(RST),
        .load(seq_load),
        .count(seq_count),
        .done(seq_done)
    );

    wait_timer #(.WIDTH(`TIMER_W)) dllk_timer (
        .clk(CLK),
        .rst(RST),
        .load(dllk_load),
        .count(`TIMER_W'(T_DLLK)),
        .done(dllk_done)
    );

    // ============================================================
    // stable-clock pin: three flops, a change counts once the last two agree
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stable_sync <= 3'h0;
            clk_ok <= 1'b0;
        end else begin
            stable_sync <= {stable_sync[1:0], CLK_STABLE};
            if (stable_sync[1] == stable_sync[2]) begin
                clk_ok <= stable_sync[2];
            end
        end
    end

    // ============================================================
    // step sequencer; every issue state loads the gap before the next step
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= dll_switch_pkg::ST_IDLE;
            after <= dll_switch_pkg::ST_IDLE;
            seq_load <= 1'b0;
            seq_count <= '0;
            dllk_load <= 1'b0;
            dll_on_dir <= 1'b0;
            DONE <= 1'b0;
        end else begin
            seq_load <= 1'b0;
            dllk_load <= 1'b0;
            DONE <= 1'b0;
            case (state)
                dll_switch_pkg::ST_IDLE: begin
                    if (START) begin // see [RULE1]
                        dll_on_dir <= TO_DLL_ON;
                        state <= TO_DLL_ON ? dll_switch_pkg::ST_SRE : dll_switch_pkg::ST_MR1_OFF;
                    end
                end
                dll_switch_pkg::ST_MR1_OFF: begin // see [RULE12]
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_MOD);
                    after <= dll_switch_pkg::ST_SRE;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_SRE: begin // see [RULE2]
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_CKSRE);
                    after <= dll_switch_pkg::ST_FREQ;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_FREQ: begin
                    // the clock source raises its flag only once the new rate holds
                    if (clk_ok) begin // see [RULE3]
                        seq_load <= 1'b1;
                        seq_count <= `TIMER_W'(T_CKSRX);
                        after <= dll_switch_pkg::ST_SRX;
                        state <= dll_switch_pkg::ST_WAIT;
                    end
                end
                dll_switch_pkg::ST_SRX: begin
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_XS);
                    after <= dll_on_dir ? dll_switch_pkg::ST_MR1_ON : dll_switch_pkg::ST_MR_UPDATE;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_MR1_ON: begin // see [RULE6]
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_MRD);
                    after <= dll_switch_pkg::ST_MR0_RESET;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_MR0_RESET: begin // see [RULE7]
                    dllk_load <= 1'b1;
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_MRD);
                    after <= dll_switch_pkg::ST_MR_UPDATE;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_MR_UPDATE: begin // see [RULE8]
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_MOD);
                    after <= dll_switch_pkg::ST_MR_LAST;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_MR_LAST: begin
                    // mr0 with the new cl/wr and dll reset cleared; the last mode write on both paths
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_MOD); // see [RULE10]
                    after <= ZQ_LONG_EN ? dll_switch_pkg::ST_ZQCL : dll_switch_pkg::ST_FINISH;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_ZQCL: begin // see [RULE9]
                    seq_load <= 1'b1;
                    seq_count <= `TIMER_W'(T_ZQOPER); // see [RULE11]
                    after <= dll_switch_pkg::ST_FINISH;
                    state <= dll_switch_pkg::ST_WAIT;
                end
                dll_switch_pkg::ST_FINISH: begin
                    // commands needing a locked dll wait out the lock window
                    if (dllk_done || !dll_on_dir) begin // see [RULE10]
                        DONE <= 1'b1;
                        state <= dll_switch_pkg::ST_IDLE;
                    end
                end
                dll_switch_pkg::ST_WAIT: begin
                    if (seq_done) begin
                        state <= after;
                    end
                end
                default: begin
                    state <= dll_switch_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // record termination use at start and at self refresh entry;
    // latching at start already keeps odt low on the first command
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            odt_used <= 1'b0;
        end else if ((state == dll_switch_pkg::ST_IDLE && START)
                || state == dll_switch_pkg::ST_SRE) begin // see [RULE1]
            odt_used <= ODT_FEATURES_ON; // see [RULE16]
        end
    end

    // ============================================================
    // command pins; one command cycle per issue state, nop otherwise
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pins <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                      ba: 3'h0, addr: 16'h0000};
        end else begin
            pins.cs_n <= 1'b0;
            {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h7;
            pins.ba <= 3'h0;
            pins.addr <= 16'h0000;
            case (state)
                dll_switch_pkg::ST_IDLE: begin
                    pins.cke <= 1'b1;
                end
                dll_switch_pkg::ST_MR1_OFF: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h0;
                    pins.ba <= `MR1_SEL;
                    pins.addr <= MR1_VALUE | (16'h0001 << `MR1_DLL_OFF_BIT); // see [RULE12]
                end
                dll_switch_pkg::ST_SRE: begin
                    // refresh with cke low is self refresh entry
                    pins.cke <= 1'b0;
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h1;
                end
                dll_switch_pkg::ST_SRX: begin
                    pins.cke <= 1'b1; // see [RULE4]
                end
                dll_switch_pkg::ST_MR1_ON: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h0;
                    pins.ba <= `MR1_SEL;
                    pins.addr <= MR1_VALUE & ~(16'h0001 << `MR1_DLL_OFF_BIT); // see [RULE6]
                end
                dll_switch_pkg::ST_MR0_RESET: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h0;
                    pins.ba <= `MR0_SEL;
                    pins.addr <= MR0_VALUE | (16'h0001 << `MR0_DLL_RESET_BIT); // see [RULE7]
                end
                dll_switch_pkg::ST_MR_UPDATE: begin
                    // user supplies cwl 6 here when switching off, see [RULE15]
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h0;
                    pins.ba <= `MR2_SEL;
                    pins.addr <= MR2_VALUE; // see [RULE8]
                end
                dll_switch_pkg::ST_MR_LAST: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h0;
                    pins.ba <= `MR0_SEL;
                    pins.addr <= MR0_VALUE & ~(16'h0001 << `MR0_DLL_RESET_BIT);
                end
                dll_switch_pkg::ST_ZQCL: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h6;
                    pins.addr <= 16'h0001 << `ZQ_LONG_BIT; // see [RULE9]
                end
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // status and odt; odt forced low through the whole switch when used
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ODT <= 1'b0;
            BUSY <= 1'b0;
            FREQ_CHANGE_OK <= 1'b0;
        end else begin
            BUSY <= (state != dll_switch_pkg::ST_IDLE);
            FREQ_CHANGE_OK <= (state == dll_switch_pkg::ST_FREQ);
            if (state == dll_switch_pkg::ST_IDLE) begin
                ODT <= ODT_REQ;
            end else begin
                ODT <= odt_used ? 1'b0 : ODT_REQ; // see [RULE5]
            end
        end
    end

    assign CKE = pins.cke;
    assign CS_N = pins.cs_n;
    assign RAS_N = pins.ras_n;
    assign CAS_N = pins.cas_n;
    assign WE_N = pins.we_n;
    assign BA = pins.ba;
    assign ADDR = pins.addr;
endmodule : dll_mode_switch_sequencer
`default_nettype wire

//--- dll_switch_consts.svh
// constants for the dll on/off switch sequencer
`ifndef DLL_SWITCH_CONSTS_SVH
`define DLL_SWITCH_CONSTS_SVH
// ============================================================
// controller clock
`define CLK_PERIOD_PS 10000
// ns figure to whole cycles, rounded up, never below one
`define NS_TO_CYC(ns) ((((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
    (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
// ============================================================
// timing defaults (clock counts unless named _NS)
`define T_MRD_CK 4
`define T_MOD_CK 12
`define T_MOD_NS 15
`define T_CKSRE_CK 5
`define T_CKSRE_NS 10
`define T_CKSRX_CK 5
`define T_CKSRX_NS 10
`define T_XS_NS 270
`define T_DLLK_CK 512
`define T_ZQOPER_CK 512
`define TIMER_W 12
// ============================================================
// mode register bank selects and bit positions
`define MR0_SEL 3'h0
`define MR1_SEL 3'h1
`define MR2_SEL 3'h2
`define MR1_DLL_OFF_BIT 0
`define MR0_DLL_RESET_BIT 8
`define ZQ_LONG_BIT 10
`endif

//--- dll_switch_monitor.sv
// port checker for the dll switch sequencer
`default_nettype none
module dll_switch_monitor #(
    parameter int T_CKSRE = 5, // sre clock hold
    parameter int T_XS = 27, // exit to first mrs
    parameter int T_DLLK = 512 // dll lock
) (
    input wire logic CLK, // clock
    input wire logic RST, // reset, high
    input wire logic START, // begin pulse
    input wire logic TO_DLL_ON, // direction
    input wire logic ODT_FEATURES_ON, // odt in use
    input wire logic FREQ_CHANGE_OK, // clock may change
    input wire logic BUSY, // running
    input wire logic DONE, // finished
    input wire logic CKE, // clock enable
    input wire logic CS_N, // chip select
    input wire logic RAS_N, // row strobe
    input wire logic CAS_N, // column strobe
    input wire logic WE_N, // write enable
    input wire logic [2:0] BA, // bank
    input wire logic [15:0] ADDR, // address
    input wire logic ODT // termination
);
    logic mrs;
    logic dir;
    logic odt_rec;
    logic srx_seen;
    logic [1:0] mrs_n;
    logic [15:0] since_sre;
    logic [15:0] since_srx;
    logic [15:0] since_rst;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    assign mrs = !CS_N && !RAS_N && !CAS_N && !WE_N;
    // ======
    // run context: direction and termination use at entry
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dir <= 1'b0;
            odt_rec <= 1'b0;
        end else begin
            if (START && !BUSY) dir <= TO_DLL_ON;
            if ($fell(CKE) && BUSY) odt_rec <= ODT_FEATURES_ON;
        end
    end
    // exit and reset counters saturate so a long idle never wraps into a false pass
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            since_sre <= 16'h0000;
            since_srx <= 16'h0000;
            since_rst <= 16'h0000;
            srx_seen <= 1'b0;
            mrs_n <= 2'h0;
        end else begin
            since_sre <= CKE ? 16'h0000 : since_sre + 16'h0001;
            if (since_srx != 16'hFFFF) since_srx <= since_srx + 16'h0001;
            if (since_rst != 16'hFFFF) since_rst <= since_rst + 16'h0001;
            if (mrs && BA == 3'h0 && ADDR[8]) since_rst <= 16'h0001;
            if (mrs && srx_seen && mrs_n != 2'h3) mrs_n <= mrs_n + 2'h1;
            if ($rose(CKE) && BUSY) begin
                srx_seen <= 1'b1;
                since_srx <= 16'h0001;
            end
            if (DONE) begin
                srx_seen <= 1'b0;
                mrs_n <= 2'h0;
            end
        end
    end
    // ======
    // assertions
    mrs_spacing_a: assert property (mrs |=> !mrs [*3])
        else $error("mode register writes too close");
    freq_hold_a: assert property (FREQ_CHANGE_OK |-> !CKE && since_sre >= T_CKSRE)
        else $error("clock change allowed too early");
    cke_hold_a: assert property (srx_seen |-> CKE)
        else $error("clock enable dropped after exit");
    odt_hold_a: assert property (srx_seen && odt_rec |-> !ODT)
        else $error("termination raised during lock");
    entry_odt_a: assert property (BUSY && !CKE && ODT_FEATURES_ON |-> !ODT)
        else $error("termination raised at self refresh entry");
    exit_wait_a: assert property (mrs && srx_seen |-> since_srx >= T_XS)
        else $error("mode write before exit wait");
    dll_enable_a: assert property (dir && srx_seen && mrs && mrs_n == 2'h0
        |-> BA == 3'h1 && !ADDR[0]) else $error("first write not dll enable");
    dll_reset_a: assert property (dir && srx_seen && mrs && mrs_n == 2'h1
        |-> BA == 3'h0 && ADDR[8]) else $error("second write not dll reset");
    lock_wait_a: assert property (DONE && dir |-> since_rst >= T_DLLK)
        else $error("ready before dll lock");
    dll_disable_a: assert property (!dir && BUSY && !srx_seen && CKE && mrs
        |-> BA == 3'h1 && ADDR[0]) else $error("entry write not dll disable");
endmodule : dll_switch_monitor
`default_nettype wire

//--- dll_switch_pkg.sv
// types shared by the dll on/off switch sequencer
`default_nettype none
package dll_switch_pkg;
    // ============================================================
    // command pins as one bundle
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] addr;
    } pins_type;

    typedef enum {
        ST_IDLE, ST_MR1_OFF, ST_SRE, ST_FREQ, ST_CKSRX, ST_SRX, ST_MR1_ON, ST_MR0_RESET,
        ST_MR_UPDATE, ST_MR_LAST, ST_ZQCL, ST_FINISH, ST_WAIT
    } state_type;
endpackage : dll_switch_pkg
`default_nettype wire

//--- dram_model.sv
// behavioural dram: decodes commands, keeps mode registers and dll state
`default_nettype none
module dram_model (
    input wire logic clk, // command clock
    input wire logic rst, // reset, high
    input wire dll_switch_pkg::pins_type pins, // command pins
    output logic dll_on, // dll enabled
    output logic [15:0] mr0, // mode register 0
    output logic [15:0] mr1, // mode register 1
    output logic [15:0] mr2, // mode register 2
    output logic [7:0] resets, // dll resets seen
    output logic [7:0] zqs, // long calibrations seen
    output logic [7:0] faults // illegal commands seen
);
    logic in_sr;
    logic nop;
    logic mrs;
    logic [7:0] gap;
    assign mrs = !pins.cs_n && !pins.ras_n && !pins.cas_n && !pins.we_n;
    assign nop = pins.cs_n || (pins.ras_n && pins.cas_n && pins.we_n);
    // ======
    // mode registers; dll enable follows mr1 a0 as written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dll_on <= 1'b0;
            mr0 <= 16'h0000;
            mr1 <= 16'h0001;
            mr2 <= 16'h0000;
            resets <= 8'h00;
        end else if (mrs) begin
            if (pins.ba == 3'h0) mr0 <= pins.addr;
            if (pins.ba == 3'h1) mr1 <= pins.addr;
            if (pins.ba == 3'h2) mr2 <= pins.addr;
            if (pins.ba == 3'h1) dll_on <= !pins.addr[0];
            if (pins.ba == 3'h0 && pins.addr[8]) resets <= resets + 8'h01;
        end
    end
    // self refresh tracking; only nop is legal while asleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_sr <= 1'b0;
            gap <= 8'hFF;
            zqs <= 8'h00;
            faults <= 8'h00;
        end else begin
            if (gap != 8'hFF) gap <= gap + 8'h01;
            if (mrs) gap <= 8'h01;
            if (!pins.cke && !pins.cs_n && !pins.ras_n && !pins.cas_n) in_sr <= 1'b1;
            if (in_sr && pins.cke) in_sr <= 1'b0;
            if (!pins.cs_n && pins.ras_n && pins.cas_n && !pins.we_n && pins.addr[10])
                zqs <= zqs + 8'h01;
            if ((mrs && gap < 8'h04) || (in_sr && !pins.cke && !nop))
                faults <= faults + 8'h01;
        end
    end
endmodule : dram_model
`default_nettype wire

//--- test_dll_mode_switch_sequencer.sv
// testbench for the dll switch sequencer against the dram model
`default_nettype none
module test_dll_mode_switch_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    // short timings keep the run brief
    localparam int T_MRD = 4;
    localparam int T_MOD = 6;
    localparam int T_CKSRE = 4;
    localparam int T_CKSRX = 5;
    localparam int T_XS = 8;
    localparam int T_DLLK = 40;
    localparam int T_ZQOPER = 60;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, to_on = 1'b0, odt_on = 1'b0;
    logic zq_en = 1'b0, odt_req = 1'b0, stable = 1'b0;
    logic [15:0] mr0_v = 16'h0000, mr1_v = 16'h0000, mr2_v = 16'h0000;
    logic freq_ok, busy, done, cke, cs_n, ras_n, cas_n, we_n, odt, dll_on;
    logic [2:0] ba;
    logic [15:0] addr, mr0, mr1, mr2;
    logic [7:0] resets, zqs, faults;
    dll_switch_pkg::pins_type pins;
    int fail_count = 0;
    int checked = 0;
    assign pins = {cke, cs_n, ras_n, cas_n, we_n, ba, addr};
    dll_mode_switch_sequencer #(.T_MRD(T_MRD), .T_MOD(T_MOD), .T_CKSRE(T_CKSRE),
        .T_CKSRX(T_CKSRX), .T_XS(T_XS), .T_DLLK(T_DLLK), .T_ZQOPER(T_ZQOPER)) dut (
        .CLK(clk), .RST(rst), .START(start), .TO_DLL_ON(to_on), .ODT_FEATURES_ON(odt_on),
        .ZQ_LONG_EN(zq_en), .MR0_VALUE(mr0_v), .MR1_VALUE(mr1_v), .MR2_VALUE(mr2_v),
        .ODT_REQ(odt_req), .CLK_STABLE(stable), .FREQ_CHANGE_OK(freq_ok), .BUSY(busy),
        .DONE(done), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
        .BA(ba), .ADDR(addr), .ODT(odt));
    dram_model mem (.clk(clk), .rst(rst), .pins(pins), .dll_on(dll_on), .mr0(mr0),
        .mr1(mr1), .mr2(mr2), .resets(resets), .zqs(zqs), .faults(faults));
    // ======
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic wait_limit(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            end_sim();
        end
    endtask : wait_limit
    // one switch; poke fires a second start while busy, which must be ignored
    task automatic do_switch(input logic d, input logic poke, output int cyc);
        int n;
        stable = 1'b0;
        @(negedge clk);
        to_on = d;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        cyc = 1;
        if (poke) begin
            repeat (3) @(negedge clk);
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            cyc += 4;
        end
        for (n = 0; n < 300 && freq_ok !== 1'b1; n++) @(negedge clk);
        wait_limit(n, 300);
        stable = 1'b1;
        cyc += n;
        for (n = 0; n < 300 && cke !== 1'b1; n++) @(negedge clk);
        wait_limit(n, 300);
        check("stable_to_exit", {15'h0000, n > T_CKSRX}, 16'h0001);
        cyc += n;
        for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge clk);
        wait_limit(n, 2000);
        cyc += n;
    endtask : do_switch
    // ======
    // scenarios
    task automatic scen_switch_on;
        int cyc;
        odt_on = 1'b1;
        zq_en = 1'b1;
        odt_req = 1'b1;
        mr0_v = 16'h0024;
        mr1_v = 16'h0045;
        mr2_v = 16'h0010;
        do_switch(1'b1, 1'b1, cyc);
        check("dll_on", {15'h0000, dll_on}, 16'h0001);
        check("mr1", mr1, mr1_v & 16'hFFFE);
        check("dll_resets", {8'h00, resets}, 16'h0001);
        check("mr0", mr0, mr0_v);
        check("mr2", mr2, mr2_v);
        check("zq_long", {8'h00, zqs}, 16'h0001);
        check("ready_wait", {15'h0000, cyc >= T_XS + 2 * T_MRD + 2 * T_MOD + T_ZQOPER},
            16'h0001);
        check("faults", {8'h00, faults}, 16'h0000);
        repeat (20) @(negedge clk);
        check("busy_after", {15'h0000, busy}, 16'h0000);
        check("odt_free", {15'h0000, odt}, 16'h0001);
    endtask : scen_switch_on
    task automatic scen_switch_off;
        int cyc;
        odt_on = 1'b0;
        zq_en = 1'b0;
        odt_req = 1'b0;
        mr0_v = 16'h0020; // cl6 code, user chosen
        mr2_v = 16'h0008; // cwl6 code, user chosen
        do_switch(1'b0, 1'b0, cyc);
        check("dll_off", {15'h0000, dll_on}, 16'h0000);
        check("mr1_off", mr1, mr1_v | 16'h0001);
        check("resets_off", {8'h00, resets}, 16'h0001);
        check("zq_off", {8'h00, zqs}, 16'h0001);
        check("mr0_off", mr0, mr0_v);
        check("mr2_off", mr2, mr2_v);
        check("faults_off", {8'h00, faults}, 16'h0000);
        check("odt_low", {15'h0000, odt}, 16'h0000);
    endtask : scen_switch_off
    task automatic scen_reset_mid;
        @(negedge clk);
        to_on = 1'b1;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (6) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check("rst_pins", {12'h000, cke, cs_n, busy, freq_ok}, 16'h0004);
        rst = 1'b0;
        @(negedge clk);
        check("rst_nop", {14'h0000, cke, cs_n}, 16'h0002);
    endtask : scen_reset_mid
    // ======
    // clock and main sequence
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        scen_switch_on();
        scen_switch_off();
        scen_reset_mid();
        end_sim();
    end
endmodule : test_dll_mode_switch_sequencer
bind dll_mode_switch_sequencer dll_switch_monitor #(.T_CKSRE(T_CKSRE), .T_XS(T_XS),
    .T_DLLK(T_DLLK)) mon (.CLK(CLK), .RST(RST), .START(START), .TO_DLL_ON(TO_DLL_ON),
    .ODT_FEATURES_ON(ODT_FEATURES_ON), .FREQ_CHANGE_OK(FREQ_CHANGE_OK), .BUSY(BUSY),
    .DONE(DONE), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
    .BA(BA), .ADDR(ADDR), .ODT(ODT));
`default_nettype wire

//--- wait_timer.sv
// down-counting wait timer, done once the loaded count has run out
`default_nettype none
module wait_timer #(
    parameter int WIDTH = 12
) (
    input wire logic clk, // controller clock
    input wire logic rst, // async reset, high
    input wire logic load, // start a wait
    input wire logic [WIDTH-1:0] count, // cycles to wait
    output logic done // wait over, level
);
    logic [WIDTH-1:0] remain;

    initial begin
        if (WIDTH < 4) $error("wait_timer: width too small");
    end

    // ============================================================
    // count down; a fresh load restarts the wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done = (remain == '0) && !load;
endmodule : wait_timer
`default_nettype wire
